// ==== common/io_station_defs.svh ====
// constants of the stand-alone i/o station: widths, field positions, timing
// assumes nothing; included by the package and by the top module
`ifndef IO_STATION_DEFS_SVH
`define IO_STATION_DEFS_SVH

`define IOS_IO_W            32
`define IOS_BLOCK_W         64
`define IOS_HALF_W          16
`define IOS_ID_W            6
`define IOS_SLOT_IDX_W      7
`define IOS_STATIONS        64
`define IOS_SLOT_CNT_W      16
`define IOS_SLOT_CYCLES     64
`define IOS_GROUP_PINS      4
`define IOS_DIR_ALL_OUT     3'h7

// layout of the configuration word in the upper half of the own block
`define IOS_CFG_SPLIT_LSB   0
`define IOS_CFG_SWAP_BIT    3
`define IOS_CFG_POL_LSB     4
`define IOS_CFG_HALF_BIT    12
`define IOS_CFG_CLEAR_LOW_HALF_N_BIT    13
`define IOS_CFG_CLEAR_HIGH_HALF_N_BIT    14
`define IOS_CFG_SRC_LSB     15
`define IOS_CFG_USED_W      21

`define IOS_BLOCK_RESET     64'h0000_0000_0000_0000
`define IOS_OUT_RESET       32'h0000_0000

`endif

// ==== common/io_station_pkg.sv ====
// types shared by the i/o station and its pin selector bank
// assumes the defs header is on the include path
`default_nettype none

package io_station_pkg;
	`include "io_station_defs.svh"

	typedef logic [`IOS_IO_W-1:0]    io_word_t;
	typedef logic [`IOS_BLOCK_W-1:0] block_t;
	typedef logic [`IOS_ID_W-1:0]    station_id_t;
	typedef logic [2:0]              dir_code_t;
	typedef logic [7:0]              polarity_t;

	typedef struct packed {
		logic [`IOS_SLOT_CNT_W-1:0] slot_cnt;
		logic [`IOS_SLOT_IDX_W-1:0] slot_idx;
		logic                       running;
		logic                       in_strobe;
		logic                       rx_strobe;
		logic                       out_strobe;
		block_t                     block;
		io_word_t                   out_bits;
	} station_state_t;

	// pins that drive: top 4k pins for code k, all pins for code 7
	function automatic io_word_t out_mask(input dir_code_t k);
		io_word_t m;
		m = '0;
		for (int i = 0; i < `IOS_IO_W; i++)
		begin
			if (k == `IOS_DIR_ALL_OUT)
				m[i] = 1'b1;
			else if (i >= `IOS_IO_W - `IOS_GROUP_PINS * int'(k))
				m[i] = 1'b1;
		end
		return m;
	endfunction

	// one polarity input per group of four neighbouring pins
	function automatic io_word_t expand_polarity(input polarity_t p);
		io_word_t m;
		m = '0;
		for (int i = 0; i < `IOS_IO_W; i++)
			m[i] = p[i / `IOS_GROUP_PINS];
		return m;
	endfunction
endpackage

`default_nettype wire

// ==== common/pin_select_if.sv ====
// carrier between the station core and its pin selector bank
// assumes both ends share one clock-free combinational path
`default_nettype none

interface pin_select_if;
	import io_station_pkg::*;
	io_word_t  dir_out;
	io_word_t  invert;
	io_word_t  out_bits;
	io_word_t  pin_in;
	io_word_t  in_bits;
	io_word_t  pin_out;
	io_word_t  pin_oe;

	modport station (output dir_out, invert, out_bits, pin_in,
		input in_bits, pin_out, pin_oe);
	modport bank (input dir_out, invert, out_bits, pin_in,
		output in_bits, pin_out, pin_oe);
endinterface

`default_nettype wire

// ==== sim/io_station_chk.sv ====
// port checker of the i/o station
// assumes the package is compiled first
`default_nettype none
module io_station_chk
	import io_station_pkg::*;
(
	// watched ports
	input wire logic        i_clk, i_rst, i_mode_select, i_rx_valid,
	input wire logic        i_output_half_select_n, i_direction_swap_n,
	input wire logic        i_clear_low_half_n, i_clear_high_half_n,
	input wire logic        o_rx_strobe, o_output_update_strobe,
	input wire logic        o_input_sample_strobe, o_tx_request,
	input wire station_id_t i_station_address_n, i_rx_station,
	input wire station_id_t i_source_station_select_n,
	input wire dir_code_t   i_direction_split_select,
	input wire polarity_t   i_group_polarity_invert,
	input wire block_t      i_rx_block, o_tx_block,
	input wire io_word_t    i_io_pin, o_io_pin, o_io_pin_oe,
	input wire io_word_t    o_internal_output_bits
);
	io_word_t inv, mask, smp, half;
	logic     take, hit;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	always_comb
	begin
		for (int i = 0; i < 32; i++)
			inv[i] = i_group_polarity_invert[i / 4];
		// named copies, so the sampled-value calls see plain signals
		smp = i_io_pin ^ inv;
		half = i_output_half_select_n ? i_rx_block[31:0] : i_rx_block[63:32];
		mask = ~(32'hFFFF_FFFF >> (4 * i_direction_split_select));
		if (i_direction_split_select == 3'h7)
			mask = 32'hFFFF_FFFF;
		take = i_rx_valid && i_mode_select
			&& i_rx_station != ~i_station_address_n;
		hit = take && i_rx_station == ~i_source_station_select_n;
	end
	property p_rx;
		!$past(i_rst) |-> {o_rx_strobe, o_output_update_strobe}
			== {$past(take), $past(hit)};
	endproperty
	a_rx: assert property (p_rx) else $error("receive strobes wrong");
	property p_load;
		hit && i_clear_low_half_n && i_clear_high_half_n |=>
			o_internal_output_bits == $past(half);
	endproperty
	a_load: assert property (p_load) else $error("latch load wrong");
	property p_clear_low_half_n;
		!i_clear_low_half_n |=> o_internal_output_bits[15:0] == 16'h0000;
	endproperty
	a_clear_low_half_n: assert property (p_clear_low_half_n) else $error("low clear lost");
	property p_clear_high_half_n;
		!i_clear_high_half_n |=> o_internal_output_bits[31:16] == 16'h0000;
	endproperty
	a_clear_high_half_n: assert property (p_clear_high_half_n) else $error("high clear lost");
	// reset is the subject here, so it cannot also disable the check
	property p_rst;
		disable iff (1'b0) i_rst |=> o_internal_output_bits == 32'h0000_0000
			&& !o_output_update_strobe;
	endproperty
	a_rst: assert property (p_rst) else $error("reset clear lost");
	property p_oe;
		o_io_pin_oe == (i_direction_swap_n ? mask : ~mask);
	endproperty
	a_oe: assert property (p_oe) else $error("pin direction wrong");
	property p_pin;
		o_io_pin == ((o_internal_output_bits ^ inv) & o_io_pin_oe);
	endproperty
	a_pin: assert property (p_pin) else $error("pin level wrong");
	property p_smp;
		o_input_sample_strobe |-> o_tx_request && o_tx_block[31:0]
			== $past(smp) ##1 !o_input_sample_strobe;
	endproperty
	a_smp: assert property (p_smp) else $error("sample wrong");
endmodule
bind io_station io_station_chk chk_u (.*);
`default_nettype wire

// ==== sim/net_peer_model.sv ====
// peer stations: cycle starts and received packets
// assumes the bench raises requests between clock edges
`default_nettype none
module net_peer_model
	import io_station_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_go,
	input  wire logic        i_cyc,
	input  wire station_id_t i_st,
	input  wire block_t      i_blk,
	output var  logic        o_valid,
	output var  logic        o_cycle_start,
	output var  station_id_t o_st,
	output var  block_t      o_blk
);
	// idle bus toggles so no stale packet passes for a new one
	always @(posedge i_clk)
	begin
		o_valid <= i_go;
		o_cycle_start <= i_cyc;
		o_st <= i_go ? i_st : ~o_st;
		o_blk <= i_go ? i_blk : ~o_blk;
	end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the i/o station
// assumes package, peer model and checker are compiled first
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import io_station_pkg::*;
	localparam int SLOT = 4;
	localparam station_id_t ME = 6'h02;
	localparam station_id_t SRC = 6'h05;
	localparam block_t B1 = 64'hAAAA_5555_1234_5678;
	localparam block_t B2 = 64'h0000_0000_FFFF_FFFF;
	typedef struct packed {
		station_id_t s;
		logic        h;
		block_t      b;
		logic [1:0]  st;
		io_word_t    e;
	} row_t;
	row_t rows [4] = '{'{SRC, 1'b0, B1, 2'b11, 32'hAAAA_5555},
		'{SRC, 1'b1, B1, 2'b11, 32'h1234_5678},
		'{6'h07, 1'b1, B2, 2'b10, 32'h1234_5678},
		'{ME, 1'b1, B2, 2'b00, 32'h1234_5678}};
	logic i_clk = 0, i_rst = 1, i_mode_select = 1, go = 0, cyc = 0;
	logic i_output_half_select_n = 1, i_direction_swap_n = 1;
	logic i_clear_low_half_n = 1, i_clear_high_half_n = 1;
	logic i_cycle_start, i_rx_valid, o_tx_request, o_rx_strobe;
	logic o_input_sample_strobe, o_output_update_strobe;
	logic [1:0] sv;
	station_id_t i_station_address_n = ~ME, i_rx_station, st = SRC;
	station_id_t i_source_station_select_n = ~SRC, o_station_identity;
	dir_code_t i_direction_split_select = 3'h0;
	polarity_t i_group_polarity_invert = 8'hA5;
	block_t i_rx_block, o_tx_block, blk = B2;
	io_word_t i_io_pin = 32'hC3A5_0F96, o_io_pin, o_io_pin_oe, m, inv;
	io_word_t o_internal_output_bits;
	int num_errors = 0, checks = 0, n;
	io_station #(.SLOT_CYCLES(SLOT)) dut_u (.*);
	net_peer_model peer_u (.i_clk, .i_go(go), .i_cyc(cyc), .i_st(st),
		.i_blk(blk), .o_valid(i_rx_valid), .o_cycle_start(i_cycle_start),
		.o_st(i_rx_station), .o_blk(i_rx_block));
	assign sv = {o_rx_strobe, o_output_update_strobe};
	always #2.5 i_clk = ~i_clk;
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (!ok)
		begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic send(input station_id_t s, input block_t b);
		@(negedge i_clk);
		st = s;
		blk = b;
		go = 1;
		@(negedge i_clk);
		go = 0;
		@(negedge i_clk);
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		for (int i = 0; i < 32; i++)
			inv[i] = i_group_polarity_invert[i / 4];
		repeat (10) @(negedge i_clk);
		chk(o_internal_output_bits === 32'h0000_0000, "reset");
		chk(o_station_identity === ME, "identity");
		i_rst = 0;
		foreach (rows[k])
		begin
			i_output_half_select_n = rows[k].h;
			send(rows[k].s, rows[k].b);
			chk(sv === rows[k].st, "strobes");
			chk(o_internal_output_bits === rows[k].e, "bits");
		end
		// a clear must win over a load landing on the same edge
		i_clear_low_half_n = 0;
		send(SRC, B2);
		chk(o_internal_output_bits === 32'hFFFF_0000, "low clear");
		i_clear_low_half_n = 1;
		i_clear_high_half_n = 0;
		send(SRC, B2);
		chk(o_internal_output_bits === 32'h0000_FFFF, "high clear");
		i_clear_high_half_n = 1;
		i_mode_select = 0;
		send(SRC, B1);
		chk(sv === 2'b00, "mode low");
		i_mode_select = 1;
		for (int k = 0; k < 16; k++)
		begin
			@(negedge i_clk);
			i_direction_split_select = k[2:0];
			i_direction_swap_n = k[3];
			#1;
			m = ~(32'hFFFF_FFFF >> (4 * k[2:0]));
			m = (k[2:0] == 3'h7) ? 32'hFFFF_FFFF : m;
			m = k[3] ? m : ~m;
			chk(o_io_pin_oe === m, "direction");
			m = (o_internal_output_bits ^ inv) & m;
			chk(o_io_pin === m, "pin level");
		end
		@(negedge i_clk);
		cyc = 1;
		@(negedge i_clk);
		cyc = 0;
		n = 1;
		while (o_input_sample_strobe !== 1'b1 && n < 40)
		begin
			@(negedge i_clk);
			n++;
		end
		// one edge through the peer model, one through the strobe register
		chk(n == int'(ME) * SLOT + 2, "slot");
		chk(o_tx_request === 1'b1, "tx request");
		chk(o_tx_block[31:0] === (i_io_pin ^ inv), "sample");
		m = {11'h000, ~SRC, 3'b111, 8'hA5, 1'b1, 3'h7};
		chk(o_tx_block[63:32] === m, "config");
		i_rst = 1;
		@(negedge i_clk);
		chk(o_internal_output_bits === 32'h0000_0000, "mid reset");
		i_rst = 0;
		end_of_test();
	end
endmodule
`default_nettype wire

// ==== src/io_station.sv ====
// stand-alone i/o station: own block build, remote block latch, pin mux
// assumes a network core delivers cycle starts and received blocks
`default_nettype none
`include "io_station_defs.svh"

// Contract
// - identity comes from the six address inputs; one own block
// - sample strobe pulses at the start of the own transmit slot while mode select is high
// - on the sample strobe the 32 input bits fill the low half
// - upper half of the own block carries the configuration pin levels
// - the latest own block, both halves, is offered for transmission
// - the sample strobe is driven out on a pin
// - a receive strobe rises for each packet from another station while mode select is high
// - half select routes upper or lower 32 received bits to latches
// - output strobe only for packets of the selected source station
// - both 16-bit latches load together on the output strobe
// - low-half clear held low forces low 16 output bits low
// - high-half clear held low forces high 16 output bits low
// - reset forces all output bits low, ahead of any update
// - the output update strobe is driven out on a pin
// - 32 selectors join each pin to its input or output bit
// - the three split select inputs set pin directions
// - the swap input inverts the direction assignment
// - polarity low means 1 is pin high; high means 1 is pin low
// - polarity input n covers pins 4n to 4n+3
// - swap high: code k makes top 4k pins outputs, 7 makes all
module io_station
	import io_station_pkg::*;
#(
	parameter int SLOT_CYCLES = `IOS_SLOT_CYCLES
)
(
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// configuration pins
	input  wire logic                   i_mode_select,
	input  wire io_station_pkg::station_id_t i_station_address_n,
	input  wire io_station_pkg::station_id_t i_source_station_select_n,
	input  wire logic                   i_output_half_select_n,
	input  wire logic                   i_clear_low_half_n,
	input  wire logic                   i_clear_high_half_n,
	input  wire io_station_pkg::dir_code_t i_direction_split_select,
	input  wire logic                   i_direction_swap_n,
	input  wire io_station_pkg::polarity_t i_group_polarity_invert,
	// network core side
	input  wire logic                   i_cycle_start,
	input  wire logic                   i_rx_valid,
	input  wire io_station_pkg::station_id_t i_rx_station,
	input  wire io_station_pkg::block_t i_rx_block,
	output logic                        o_tx_request,
	output io_station_pkg::station_id_t o_station_identity,
	output io_station_pkg::block_t      o_tx_block,
	output logic                        o_rx_strobe,
	// external pins
	input  wire io_station_pkg::io_word_t i_io_pin,
	output io_station_pkg::io_word_t    o_io_pin,
	output io_station_pkg::io_word_t    o_io_pin_oe,
	output logic                        o_input_sample_strobe,
	output logic                        o_output_update_strobe,
	output io_station_pkg::io_word_t    o_internal_output_bits
);
	import io_station_pkg::*;

	localparam logic [`IOS_SLOT_CNT_W-1:0] SLOT_LAST =
		`IOS_SLOT_CNT_W'(SLOT_CYCLES - 1);
	localparam logic [`IOS_SLOT_IDX_W-1:0] SLOT_END =
		`IOS_SLOT_IDX_W'(`IOS_STATIONS);

	station_state_t state;
	station_state_t next_state;
	station_id_t    identity;
	station_id_t    source;
	io_word_t       internal_input_bits;
	io_word_t       config_word;
	io_word_t       rx_half;
	logic           own_slot;
	logic           rx_other;
	logic [`IOS_SLOT_IDX_W-1:0] idx_inc;

	pin_select_if sel ();

	pin_selector_bank u_bank
	(
		.sel (sel.bank)
	);

	// active-low address inputs give the identity directly
	assign identity = ~i_station_address_n;
	assign source   = ~i_source_station_select_n;

	// swap pin high keeps the decoded mask, low turns every pin round
	assign sel.dir_out = i_direction_swap_n ?
		out_mask(i_direction_split_select) :
		~out_mask(i_direction_split_select);
	assign sel.invert   = expand_polarity(i_group_polarity_invert);
	assign sel.out_bits = state.out_bits;
	assign sel.pin_in   = i_io_pin;
	assign internal_input_bits = sel.in_bits;

	// configuration levels as they stand, unused bits zero
	assign config_word = {
		{(`IOS_IO_W - `IOS_CFG_USED_W){1'b0}},
		i_source_station_select_n,
		i_clear_high_half_n,
		i_clear_low_half_n,
		i_output_half_select_n,
		i_group_polarity_invert,
		i_direction_swap_n,
		i_direction_split_select
	};

	// half select low picks the upper half of the received block
	assign rx_half = i_output_half_select_n ?
		i_rx_block[`IOS_IO_W-1:0] :
		i_rx_block[`IOS_BLOCK_W-1:`IOS_IO_W];

	assign idx_inc = state.slot_idx + `IOS_SLOT_IDX_W'(1);

	// own slot opens at cycle start for identity 0, else at a slot boundary
	always_comb
	begin
		if (i_cycle_start)
			own_slot = (identity == '0);
		else
			own_slot = state.running && (state.slot_cnt == SLOT_LAST) &&
				(idx_inc == {1'b0, identity});
	end

	// nothing is taken over the network unless the i/o mode is strapped
	assign rx_other = i_mode_select && i_rx_valid &&
		(i_rx_station != identity);

	always_comb
	begin
		next_state = state;
		next_state.in_strobe  = 1'b0;
		next_state.rx_strobe  = 1'b0;
		next_state.out_strobe = 1'b0;

		// slot timer: one slot per station, stops after the last one
		if (i_cycle_start)
		begin
			next_state.running  = 1'b1;
			next_state.slot_cnt = '0;
			next_state.slot_idx = '0;
		end
		else if (state.running)
		begin
			if (state.slot_cnt == SLOT_LAST)
			begin
				next_state.slot_cnt = '0;
				next_state.slot_idx = idx_inc;
				if (idx_inc == SLOT_END)
					next_state.running = 1'b0;
			end
			else
				next_state.slot_cnt = state.slot_cnt +
					`IOS_SLOT_CNT_W'(1);
		end

		// the upper half tracks the pins every cycle
		next_state.block[`IOS_BLOCK_W-1:`IOS_IO_W] = config_word;
		if (own_slot && i_mode_select)
		begin
			next_state.in_strobe = 1'b1;
			next_state.block[`IOS_IO_W-1:0] = internal_input_bits;
		end

		if (rx_other)
		begin
			next_state.rx_strobe = 1'b1;
			if (i_rx_station == source)
			begin
				next_state.out_strobe = 1'b1;
				next_state.out_bits   = rx_half;
			end
		end

		// clears are levels and win over a load in the same cycle
		if (!i_clear_low_half_n)
			next_state.out_bits[`IOS_HALF_W-1:0] = '0;
		if (!i_clear_high_half_n)
			next_state.out_bits[`IOS_IO_W-1:`IOS_HALF_W] = '0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state.slot_cnt   <= '0;
			state.slot_idx   <= '0;
			state.running    <= 1'b0;
			state.in_strobe  <= 1'b0;
			state.rx_strobe  <= 1'b0;
			state.out_strobe <= 1'b0;
			state.block      <= `IOS_BLOCK_RESET;
			state.out_bits   <= `IOS_OUT_RESET;
		end
		else
			state <= next_state;
	end

	// the block is offered in the cycle after its low half was sampled
	assign o_tx_request           = state.in_strobe;
	assign o_tx_block             = state.block;
	assign o_station_identity     = identity;
	assign o_rx_strobe            = state.rx_strobe;
	assign o_input_sample_strobe  = state.in_strobe;
	assign o_output_update_strobe = state.out_strobe;
	assign o_internal_output_bits = state.out_bits;
	assign o_io_pin               = sel.pin_out;
	assign o_io_pin_oe            = sel.pin_oe;
endmodule

`default_nettype wire

// ==== src/pin_selector_bank.sv ====
// 32 identical selectors joining each i/o pin to an input or output bit
// assumes direction and polarity masks are already decoded per pin
`default_nettype none

module pin_selector_bank
	import io_station_pkg::*;
(
	// selector carrier
	pin_select_if.bank sel
);
	import io_station_pkg::*;

	always_comb
	begin
		// polarity applied on the sampling path too
		sel.in_bits = sel.pin_in ^ sel.invert;
		// an input pin is not driven, its output level parks low
		sel.pin_out = (sel.out_bits ^ sel.invert) & sel.dir_out;
		sel.pin_oe  = sel.dir_out;
	end
endmodule

`default_nettype wire
